// file: verilog/p45_port_top.v
// Purpose: port 4 pin muxing with serial/interrupt, port 5 general I/O with APB registers
// Assumes: serial and mode controls come from logic on clk_sys; pins are asynchronous
// Notes: pin outputs are registered; power_mode gates pin updates
`timescale 1ns/1ps
`include "p45_map.vh"

module p45_port_top (
    input wire clk_sys, // system clock, 200 MHz
    input wire rst, // synchronous reset, active high
    input wire psel, // apb select
    input wire penable, // apb enable
    input wire pwrite, // apb direction, 1 = write
    input wire [17:0] paddr, // apb byte address
    input wire [31:0] pwdata, // apb write data
    input wire [3:0] pstrb, // apb byte strobes
    output reg [31:0] prdata, // apb read data
    output reg pready, // apb ready
    output reg pslverr, // apb error, unmapped address
    input wire [2:0] power_mode, // operating mode code
    input wire transmitter_enable_bit, // serial transmitter enable
    input wire receiver_enable_bit, // serial receiver enable
    input wire clock_enable_hi, // serial external clock select
    input wire clock_enable_lo, // serial clock output select
    input wire clock_sync_mode, // serial clocked sync mode
    input wire ext_int_select, // interrupt select bit of port2_mode_reg
    input wire serial_txd, // transmit data from serial unit
    input wire serial_clk_out, // clock from serial unit
    output reg serial_rxd, // receive data to serial unit
    output reg serial_clk_in, // external clock to serial unit
    output reg ext_interrupt_zero_n, // interrupt input, active low
    output reg [7:0] wakeup_input_n, // wakeup inputs, active low
    input wire [3:0] p4_pin_in, // port 4 pin levels
    output reg [2:0] p4_pin_out, // port 4 pin drive values
    output reg [2:0] p4_pin_oe, // port 4 output enables
    input wire [7:0] p5_pin_in, // port 5 pin levels
    output reg [7:0] p5_pin_out, // port 5 pin drive values
    output reg [7:0] p5_pin_oe, // port 5 output enables
    output reg [7:0] p5_pullup_on // port 5 pull-up controls
);

// ==========================================================
// registers and wires
reg [7:0] port5_output_latch_reg;
reg [7:0] port5_direction_reg;
reg [7:0] port5_pullup_enable_reg;
reg [7:0] port5_function_select_reg;
reg [2:0] port4_output_latch_reg;
reg [2:0] port4_direction_reg;

// only the three pin bits of the port 4 reset value are stored
localparam [7:0] P4_RST = `P45_P4_RESET;

wire [11:0] pin_q;
wire [3:0] p4_q;
wire [7:0] p5_q;
wire [15:0] reg_idx;
wire wr_access;
wire wr_lane0;
wire [7:0] wdata;

reg [2:0] p4_oe_next;
reg [2:0] p4_out_next;
wire [7:0] p5_oe_next;
wire [7:0] p5_pu_next;
wire [7:0] p5_read;
wire [7:0] wake_next;
reg [7:0] rdata_next;
reg hit_next;

// ==========================================================
// pin input synchronisers
p45_pin_sync #(
    .WIDTH(12)
) u_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .pin_in({p5_pin_in, p4_pin_in}),
    .pin_q(pin_q)
);

assign p4_q = pin_q[3:0];
assign p5_q = pin_q[11:4];

// ==========================================================
// apb decode
assign reg_idx = paddr[17:2];
assign wdata = pwdata[7:0];
assign wr_lane0 = pstrb[0];
assign wr_access = psel & penable & pready & pwrite & wr_lane0;

// ==========================================================
// port 5 per-pin logic
genvar gi;
generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_p5_pin
        // wakeup function overrides the direction bit
        assign p5_oe_next[gi] = port5_direction_reg[gi] & ~port5_function_select_reg[gi];
        // pull-up only while the pin is an input
        assign p5_pu_next[gi] = port5_pullup_enable_reg[gi] & ~port5_direction_reg[gi];
        // latch for outputs, pin for inputs
        assign p5_read[gi] = port5_direction_reg[gi] ? port5_output_latch_reg[gi] : p5_q[gi];
        assign wake_next[gi] = port5_function_select_reg[gi] ? p5_q[gi] : 1'b1;
    end
endgenerate

// ==========================================================
// port 4 pin function selection
always @* begin
    p4_oe_next = 3'h0;
    p4_out_next = port4_output_latch_reg;
    // pin 2: serial transmit overrides general I/O
    if (transmitter_enable_bit) begin
        p4_oe_next[2] = 1'b1;
        p4_out_next[2] = serial_txd;
    end else begin
        p4_oe_next[2] = port4_direction_reg[2];
    end
    // pin 1: serial receive forces input
    if (receiver_enable_bit) begin
        p4_oe_next[1] = 1'b0;
    end else begin
        p4_oe_next[1] = port4_direction_reg[1];
    end
    // pin 0: serial clock
    if (clock_enable_hi) begin
        p4_oe_next[0] = 1'b0;
    end else if (clock_enable_lo | clock_sync_mode) begin
        p4_oe_next[0] = 1'b1;
        p4_out_next[0] = serial_clk_out;
    end else begin
        p4_oe_next[0] = port4_direction_reg[0];
    end
end

// ==========================================================
// read data mux
always @* begin
    rdata_next = 8'h00;
    hit_next = 1'b1;
    case (reg_idx)
        `P45_IDX_P5_LATCH: begin
            rdata_next = p5_read;
        end
        `P45_IDX_P5_DIR: begin
            rdata_next = `P45_WO_READ;
        end
        `P45_IDX_P5_PULLUP: begin
            rdata_next = port5_pullup_enable_reg;
        end
        `P45_IDX_P5_FSEL: begin
            rdata_next = port5_function_select_reg;
        end
        `P45_IDX_P4_LATCH: begin
            // bit 3 is input only, so it always shows the pin
            rdata_next = {`P45_P4_HI_READ, p4_q[3],
                (port4_direction_reg & port4_output_latch_reg) | (~port4_direction_reg & p4_q[2:0])};
        end
        `P45_IDX_P4_DIR: begin
            rdata_next = `P45_WO_READ;
        end
        default: begin
            hit_next = 1'b0;
        end
    endcase
end

// ==========================================================
// apb slave handshake
// ready is taken in the setup cycle, so each access has no wait state
always @(posedge clk_sys) begin
    if (rst) begin
        pready <= 1'b0;
        pslverr <= 1'b0;
        prdata <= 32'h00000000;
    end else begin
        pready <= psel & ~penable;
        if (psel & ~penable) begin
            pslverr <= ~hit_next;
            prdata <= {24'h000000, rdata_next};
        end else begin
            pslverr <= 1'b0;
        end
    end
end

// ==========================================================
// register writes
always @(posedge clk_sys) begin
    if (rst) begin
        port5_output_latch_reg <= `P45_P5_RESET;
        port5_direction_reg <= `P45_P5_RESET;
        port5_pullup_enable_reg <= `P45_P5_RESET;
        port5_function_select_reg <= `P45_P5_RESET;
        port4_output_latch_reg <= P4_RST[2:0];
        port4_direction_reg <= P4_RST[2:0];
    end else if (wr_access) begin
        case (reg_idx)
            `P45_IDX_P5_LATCH: begin
                port5_output_latch_reg <= wdata;
            end
            `P45_IDX_P5_DIR: begin
                port5_direction_reg <= wdata;
            end
            `P45_IDX_P5_PULLUP: begin
                port5_pullup_enable_reg <= wdata;
            end
            `P45_IDX_P5_FSEL: begin
                port5_function_select_reg <= wdata;
            end
            `P45_IDX_P4_LATCH: begin
                port4_output_latch_reg <= wdata[2:0];
            end
            `P45_IDX_P4_DIR: begin
                port4_direction_reg <= wdata[2:0];
            end
            default: begin
                port4_direction_reg <= port4_direction_reg;
            end
        endcase
    end
end

// ==========================================================
// pin drivers, gated by power mode
// hold modes freeze drive so the pad keeps its level while clocks slow down
always @(posedge clk_sys) begin
    if (rst) begin
        p4_pin_oe <= 3'h0;
        p4_pin_out <= 3'h0;
        p5_pin_oe <= 8'h00;
        p5_pin_out <= 8'h00;
        p5_pullup_on <= 8'h00;
    end else begin
        case (power_mode)
            `P45_PM_STANDBY: begin
                p4_pin_oe <= 3'h0;
                p5_pin_oe <= 8'h00;
                p5_pullup_on <= p5_pu_next;
            end
            `P45_PM_SLEEP, `P45_PM_SUBSLEEP, `P45_PM_WATCH: begin
                p4_pin_oe <= p4_pin_oe;
                p5_pin_oe <= p5_pin_oe;
            end
            default: begin
                p4_pin_oe <= p4_oe_next;
                p4_pin_out <= p4_out_next;
                p5_pin_oe <= p5_oe_next;
                p5_pin_out <= port5_output_latch_reg;
                p5_pullup_on <= p5_pu_next;
            end
        endcase
    end
end

// ==========================================================
// inputs handed to on-chip peripherals
// idle levels are high, except serial_clk_in which idles low, so a disabled function never looks active
always @(posedge clk_sys) begin
    if (rst) begin
        serial_rxd <= 1'b1;
        serial_clk_in <= 1'b0;
        ext_interrupt_zero_n <= 1'b1;
        wakeup_input_n <= 8'hFF;
    end else begin
        serial_rxd <= receiver_enable_bit ? p4_q[1] : 1'b1;
        serial_clk_in <= clock_enable_hi ? p4_q[0] : 1'b0;
        ext_interrupt_zero_n <= ext_int_select ? p4_q[3] : 1'b1;
        wakeup_input_n <= wake_next;
    end
end

endmodule // p45_port_top

// file: inc/p45_map.vh
// Purpose: register indices, reset values and mode codes for the port 4 / port 5 block
// Assumes: APB byte address = 4 * register index
// Notes: definitions only
`ifndef P45_MAP_VH
`define P45_MAP_VH

// ==========================================================
// register indices (byte address is four times the index)
`define P45_IDX_P5_FSEL 16'hFFCC
`define P45_IDX_P4_LATCH 16'hFFD7
`define P45_IDX_P5_LATCH 16'hFFD8
`define P45_IDX_P5_PULLUP 16'hFFE2
`define P45_IDX_P4_DIR 16'hFFE7
`define P45_IDX_P5_DIR 16'hFFE8

// ==========================================================
// reset values and fixed read values
`define P45_P5_RESET 8'h00
`define P45_P4_RESET 8'hF8
`define P45_WO_READ 8'hFF
`define P45_P4_HI_READ 4'hF

// ==========================================================
// power mode codes
`define P45_PM_ACTIVE 3'h0
`define P45_PM_SUBACTIVE 3'h1
`define P45_PM_SLEEP 3'h2
`define P45_PM_SUBSLEEP 3'h3
`define P45_PM_WATCH 3'h4
`define P45_PM_STANDBY 3'h5

`endif

// file: verilog/p45_pin_sync.v
// Purpose: three-stage pin synchroniser with agreement filter
// Assumes: pins are asynchronous to clk_sys
// Notes: output rises once stages two and three are both high, and falls as soon as they differ
`timescale 1ns/1ps

module p45_pin_sync #(
    parameter WIDTH = 12
) (
    input wire clk_sys, // system clock
    input wire rst, // synchronous reset, active high
    input wire [WIDTH-1:0] pin_in, // raw pin levels
    output reg [WIDTH-1:0] pin_q // filtered levels
);

reg [WIDTH-1:0] stage1_reg;
reg [WIDTH-1:0] stage2_reg;
reg [WIDTH-1:0] stage3_reg;

// ==========================================================
// stage one feeds only stage two
always @(posedge clk_sys) begin
    if (rst) begin
        stage1_reg <= {WIDTH{1'b0}};
        stage2_reg <= {WIDTH{1'b0}};
        stage3_reg <= {WIDTH{1'b0}};
        pin_q <= {WIDTH{1'b0}};
    end else begin
        stage1_reg <= pin_in;
        stage2_reg <= stage1_reg;
        stage3_reg <= stage2_reg;
        pin_q <= (stage2_reg & stage3_reg) | (pin_q & ~(stage2_reg ^ stage3_reg));
    end
end

endmodule // p45_pin_sync

// file: bench/p45_board_model.sv
// Purpose: board side of the port pins, resolving each wire from all drivers
// Assumes: the board yields wherever the block drives
// Notes: a wire nobody holds changes every cycle so no stale level is read
`timescale 1ns/1ps

module p45_board_model #(
    parameter W = 8
) (
    input wire clk_sys, // system clock
    input wire [W-1:0] dut_out, // block drive values
    input wire [W-1:0] dut_oe, // block output enables
    input wire [W-1:0] pull_on, // block pull-up controls
    input wire [W-1:0] drv, // board drive values
    input wire [W-1:0] drv_en, // board drive enables
    output logic [W-1:0] pin // resolved wire levels
);
    logic [W-1:0] churn = '0;

    always @(posedge clk_sys) begin
        churn <= ~churn;
    end

    // a floating wire never settles, so a read of it cannot pass by luck
    assign pin = (dut_oe & dut_out) | (~dut_oe & drv_en & drv) | (~dut_oe & ~drv_en & (pull_on | churn));
endmodule // p45_board_model

// file: bench/p45_port_assertions.sv
// Purpose: port-level checks of the port 4 / port 5 block
// Assumes: one clock domain, synchronous reset
// Notes: bound to the top module below
`timescale 1ns/1ps

module p45_port_chk (
    input wire clk_sys, // system clock
    input wire rst, // reset
    input wire psel, // apb select
    input wire penable, // apb enable
    input wire pwrite, // apb direction
    input wire [17:0] paddr, // apb address
    input wire [31:0] prdata, // apb read data
    input wire pready, // apb ready
    input wire [2:0] power_mode, // mode code
    input wire transmitter_enable_bit, // tx enable
    input wire receiver_enable_bit, // rx enable
    input wire clock_enable_hi, // clock input select
    input wire clock_enable_lo, // clock output select
    input wire clock_sync_mode, // sync mode
    input wire ext_int_select, // interrupt select
    input wire serial_txd, // tx data
    input wire serial_clk_out, // serial clock
    input wire ext_interrupt_zero_n, // interrupt out
    input wire [2:0] p4_pin_out, // port 4 drive
    input wire [2:0] p4_pin_oe, // port 4 enables
    input wire [7:0] p5_pin_oe, // port 5 enables
    input wire [7:0] p5_pullup_on // port 5 pull-ups
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    // ========
    // pins
    reset_quiet_a: assert property (disable iff (1'b0)
        rst |=> p4_pin_oe == 3'h0 && p5_pin_oe == 8'h00 && !pready) else $error("driving after reset");
    standby_float_a: assert property (power_mode == 3'h5 |=> p4_pin_oe == 3'h0) else $error("standby drive");
    sleep_hold_a: assert property (
        power_mode inside {3'h2, 3'h3, 3'h4} |=> $stable(p4_pin_out) && $stable(p4_pin_oe)) else $error("not held");
    rx_input_a: assert property (
        power_mode == 3'h0 && receiver_enable_bit |=> !p4_pin_oe[1]) else $error("rx pin driven");
    tx_drive_a: assert property (
        power_mode == 3'h0 && transmitter_enable_bit |=> p4_pin_oe[2] && p4_pin_out[2] == $past(serial_txd))
        else $error("tx pin wrong");
    clk_in_a: assert property (power_mode == 3'h0 && clock_enable_hi |=> !p4_pin_oe[0])
        else $error("clock input driven");
    clk_out_a: assert property (
        power_mode == 3'h0 && !clock_enable_hi && (clock_enable_lo || clock_sync_mode)
        |=> p4_pin_oe[0] && p4_pin_out[0] == $past(serial_clk_out)) else $error("clock output wrong");
    irq_idle_a: assert property (!ext_int_select [*3] |-> ext_interrupt_zero_n) else $error("irq active");
    oe_pull_a: assert property ((p5_pin_oe & p5_pullup_on) == 8'h00) else $error("pull-up on output");

    // ========
    // register bus
    apb_ready_a: assert property (psel && !penable |=> pready ##1 !pready) else $error("ready timing");
    dir_read_a: assert property (
        psel && !penable && !pwrite && paddr == 18'h3FFA0 |=> prdata[7:0] == 8'hFF) else $error("dir read");
endmodule // p45_port_chk

bind p45_port_top p45_port_chk i_chk (.clk_sys, .rst, .psel, .penable, .pwrite, .paddr, .prdata, .pready,
    .power_mode, .transmitter_enable_bit, .receiver_enable_bit, .clock_enable_hi, .clock_enable_lo,
    .clock_sync_mode, .ext_int_select, .serial_txd, .serial_clk_out, .ext_interrupt_zero_n, .p4_pin_out,
    .p4_pin_oe, .p5_pin_oe, .p5_pullup_on);

// file: bench/tb_port4_mux_port5_gpio.sv
// Purpose: self-checking bench for the port 4 / port 5 block
// Assumes: apb answers within 16 cycles
// Notes: port 4 muxing is mostly judged by the bound checker
`timescale 1ns/1ps
`include "p45_map.vh"

module tb_port4_mux_port5_gpio;
    logic clk_sys = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, err;
    logic [17:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic [3:0] pstrb = 0, p4_in, p4_drv = 0, p4_en = 0;
    logic pready, pslverr, te = 0, re = 0, ckh = 0, ckl = 0, syn = 0, eis = 0, txd = 0, ckout = 0;
    logic rxd, ckin, irq_n;
    logic [2:0] pmode = 0, p4_out, p4_oe;
    logic [7:0] p5_in, p5_out, p5_oe, p5_pu, wake_n, ext = 0;
    int fails = 0, comparisons = 0, lat, dir, pu, fs, seed;

    always #2.5 clk_sys = ~clk_sys;

    p45_port_top i_dut (.clk_sys, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
        .pslverr, .power_mode(pmode), .transmitter_enable_bit(te), .receiver_enable_bit(re),
        .clock_enable_hi(ckh), .clock_enable_lo(ckl), .clock_sync_mode(syn), .ext_int_select(eis),
        .serial_txd(txd), .serial_clk_out(ckout), .serial_rxd(rxd), .serial_clk_in(ckin),
        .ext_interrupt_zero_n(irq_n), .wakeup_input_n(wake_n), .p4_pin_in(p4_in), .p4_pin_out(p4_out),
        .p4_pin_oe(p4_oe), .p5_pin_in(p5_in), .p5_pin_out(p5_out), .p5_pin_oe(p5_oe), .p5_pullup_on(p5_pu));
    p45_board_model #(.W(8)) i_b5 (.clk_sys, .dut_out(p5_out), .dut_oe(p5_oe), .pull_on(p5_pu), .drv(ext),
        .drv_en(8'hFF), .pin(p5_in));
    p45_board_model #(.W(4)) i_b4 (.clk_sys, .dut_out({1'b0, p4_out}), .dut_oe({1'b0, p4_oe}), .pull_on(4'h0),
        .drv(p4_drv), .drv_en(p4_en), .pin(p4_in));

    // ========
    // tasks
    task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task tally_and_finish;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // one transfer, then one idle edge so the next setup never lands in the same step
    task apb(input logic w, input logic [15:0] idx, input logic [7:0] d, input logic [3:0] sb);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h0, d};
        pstrb <= sb;
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 16) begin
            fails++;
            tally_and_finish;
        end
        @(posedge clk_sys);
    endtask

    // ========
    // sequence
    initial begin
        seed = $urandom(32'h56AE0AA1);
        repeat (4) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        apb(0, `P45_IDX_P5_FSEL, 0, 1); chk("fsel reset", rd, 0);
        apb(0, `P45_IDX_P5_PULLUP, 0, 1); chk("pullup reset", rd, 0);
        apb(0, `P45_IDX_P5_LATCH, 0, 1); chk("latch reset", rd, 0);
        chk("oe reset", p5_oe, 0);
        for (int i = 0; i < 24; i++) begin
            lat = $urandom & 255;
            dir = (i < 2) ? i * 255 : $urandom & 255;
            pu = $urandom & 255;
            fs = (i < 2) ? 0 : $urandom & 255;
            ext <= 8'($urandom);
            apb(1, `P45_IDX_P5_LATCH, lat, 1);
            apb(1, `P45_IDX_P5_DIR, dir, 1);
            apb(1, `P45_IDX_P5_PULLUP, pu, 1);
            apb(1, `P45_IDX_P5_FSEL, fs, 1);
            repeat (6) @(posedge clk_sys);
            apb(0, `P45_IDX_P5_LATCH, 0, 1); chk("latch read", rd, ((lat & dir) | (ext & ~dir)) & 255);
            apb(0, `P45_IDX_P5_PULLUP, 0, 1); chk("pullup", rd, pu);
            apb(0, `P45_IDX_P5_FSEL, 0, 1); chk("fsel", rd, fs);
            apb(0, `P45_IDX_P5_DIR, 0, 1); chk("dir read", rd, 255);
            chk("p5 oe", p5_oe, dir & ~fs & 255);
            chk("p5 pull", p5_pu, pu & ~dir & 255);
            chk("p5 out", p5_out, lat);
            chk("wakeup", wake_n, (~fs | ext) & 255);
        end
        apb(1, `P45_IDX_P5_LATCH, ~lat, 0);
        repeat (2) @(posedge clk_sys);
        chk("strobe off", p5_out, lat);
        apb(0, 16'h0001, 0, 1); chk("unmapped err", err, 1);
        apb(1, `P45_IDX_P4_DIR, 8'($urandom), 1);
        apb(1, `P45_IDX_P4_LATCH, 8'($urandom), 1);
        repeat (400) begin
            @(posedge clk_sys);
            {te, re, ckh, ckl, syn, eis, txd, ckout} <= 8'($urandom);
            pmode <= 3'($urandom % 6);
            {p4_drv, p4_en} <= 8'($urandom);
        end
        @(posedge clk_sys);
        {pmode, eis, re, ckh, p4_en} <= {3'h0, 3'b111, 4'hF};
        for (int v = 0; v < 2; v++) begin
            p4_drv <= 4'(v * 15);
            repeat (8) @(posedge clk_sys);
            chk("irq", irq_n, v);
            chk("rxd", rxd, v);
            chk("clk in", ckin, v);
        end
        rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        chk("p4 oe reset", p4_oe, 0);
        rst <= 1'b0;
        @(posedge clk_sys);
        apb(0, `P45_IDX_P5_FSEL, 0, 1); chk("fsel rereset", rd, 0);
        tally_and_finish;
    end
endmodule // tb_port4_mux_port5_gpio
